// File: rccs_pkg.sv
// Contract
// RULE_01: bit 21 picks peak-hold or average strength
// RULE_02: bit 20 mirrors wakeup pending, auto acknowledged
// RULE_03: wakeup handler waits for bit 20 clear
// RULE_04: bit 17 picks static or dynamic indication
// RULE_05: bits 14:9 hold master clock MHz
// RULE_06: clock field changed only before core enable; the register has no lock and takes clock field writes at any time
// RULE_07: bit 8 set by slow sequence after sleep
// RULE_08: bit 8 cleared on sleep exit interrupt
// RULE_09: bit 7 set per slow edge, write-zero clears
// RULE_10: no monitor set while timer in reset
// RULE_11: bit 6 shows slow or master clock
// RULE_12: bit 3 overrules diagnostic output
// RULE_13: mask bit 2 resets one, gates error
// RULE_14: bit 1 write-one clears error, reads zero
// RULE_15: bit 0 set on unmapped page access
// RULE_16: error status ignores writes except acknowledge
// RULE_17: reserved bits read zero, ignore writes
// RULE_18: error interrupt level, drops after acknowledge
package rccs_pkg;
   // register map
   localparam logic [31:0] CTRL2_ADDR = 32'h4000_0200;
   localparam logic [31:0] CTRL2_RST  = 32'h0000_0004;
   // field positions
   localparam int STRENGTH_SEL_BIT = 21;
   localparam int WAKE_STAT_BIT    = 20;
   localparam int KEEP0_HI_BIT     = 19;
   localparam int KEEP0_LO_BIT     = 18;
   localparam int PTI_SEL_BIT      = 17;
   localparam int CLK_MHZ_LSB      = 9;
   localparam int CLK_MHZ_W        = 6;
   localparam int PWRDN_OK_BIT     = 8;
   localparam int SLOW_MON_BIT     = 7;
   localparam int CLK_STAT_BIT     = 6;
   localparam int SPARE_LSB        = 4;
   localparam int DIAG_OVR_BIT     = 3;
   localparam int ERR_MASK_BIT     = 2;
   localparam int ERR_ACK_BIT      = 1;
   localparam int ERR_STAT_BIT     = 0;
   // slow-clock edges of the power-down sequence
   localparam int PWRDN_LP_EDGES   = 2;
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // master to slave
   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } rccs_axi_req_t;

   // slave to master
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } rccs_axi_rsp_t;

   // wakeup acknowledge sequence
   typedef enum logic [1:0] {
      WK_IDLE  = 2'b00,
      WK_PEND  = 2'b01,
      WK_START = 2'b10,
      WK_LAST  = 2'b11
   } rccs_wake_t;
endpackage : rccs_pkg

// File: rccs_slow_edge.sv
`timescale 1ns/10ps
// brings the slow clock and timer reset into aclk, flags rising edges
module rccs_slow_edge (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic slow_clk_pin,
   input  wire logic core_timer_reset,
   output logic      slow_edge,
   output logic      timer_in_reset
);
   typedef struct packed {
      logic [2:0] clk_sh;
      logic [1:0] rst_sh;
   } rccs_sync_t;

   rccs_sync_t s_r;
   rccs_sync_t s_nxt;

   // first stage feeds only the second stage
   always_comb begin
      s_nxt        = s_r;
      s_nxt.clk_sh = {s_r.clk_sh[1:0], slow_clk_pin};
      s_nxt.rst_sh = {s_r.rst_sh[0], core_timer_reset};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // edge taken between stages two and three
   assign slow_edge      = s_r.clk_sh[1] & ~s_r.clk_sh[2];
   assign timer_in_reset = s_r.rst_sh[1];
endmodule : rccs_slow_edge

// File: rccs_ctrl2.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
// radio core control and status register behind an axi4-lite slave
module rccs_ctrl2 #(
   parameter int DIAG_W    = 8,
   parameter int PD_EDGES  = rccs_pkg::PWRDN_LP_EDGES
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire rccs_pkg::rccs_axi_req_t axi_req,
   output rccs_pkg::rccs_axi_rsp_t    axi_rsp,
   input  wire logic                  slow_clk_pin,
   input  wire logic                  core_timer_reset,
   input  wire logic                  lowpower_wakeup_interrupt,
   input  wire logic                  radio_powered_up,
   input  wire logic                  deep_sleep_request,
   input  wire logic                  sleep_exit_interrupt,
   input  wire logic                  core_on_master_clock,
   input  wire logic                  exchange_mem_access_fault,
   input  wire logic [DIAG_W-1:0]     core_diagnostic_output,
   output logic [DIAG_W-1:0]          diag_out,
   output logic                       signal_strength_source_select,
   output logic                       pti_source_dynamic,
   output logic [5:0]                 master_clock_mhz,
   output logic                       powerdown_permitted,
   output logic                       lowpower_wakeup_status,
   output logic                       core_error_interrupt
);
   // refuse settings the counters cannot serve
   if (DIAG_W < 1 || DIAG_W > 32) begin : g_bad_diag
      $error("DIAG_W out of range");
   end
   if (PD_EDGES < 1 || PD_EDGES > 15) begin : g_bad_pd
      $error("PD_EDGES out of range");
   end

   localparam logic [3:0] PD_LAST = 4'(PD_EDGES);

   typedef struct packed {
      // write side of the bus
      logic        aw_got;
      logic [31:0] aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      // read side of the bus
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      // stored fields
      logic        strength_sel;
      logic        keep0_hi;
      logic        keep0_lo;
      logic        pti_sel;
      logic [5:0]  clk_mhz;
      logic [1:0]  spare;
      logic        diag_ovr;
      logic        err_mask;
      // hardware status
      logic        err_stat;
      logic        slow_mon;
      logic        clk_stat;
      logic        pwrdn_ok;
      logic        pd_busy;
      logic [3:0]  pd_cnt;
      rccs_pkg::rccs_wake_t wake;
      logic [DIAG_W-1:0] diag;
   } rccs_state_t;

   rccs_state_t st_r;
   rccs_state_t st_nxt;

   logic        slow_edge;
   logic        timer_in_reset;
   logic [31:0] readback;
   logic [31:0] byte_mask;
   logic [31:0] merged;
   logic        wr_fire;
   logic        wr_hit;
   logic        ack_wr;
   logic        mon_clr;

   rccs_slow_edge u_slow_edge (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .slow_clk_pin     (slow_clk_pin),
      .core_timer_reset (core_timer_reset),
      .slow_edge        (slow_edge),
      .timer_in_reset   (timer_in_reset)
   );

   // register image; reserved positions stay zero
   always_comb begin
      readback = '0; // RULE_17
      readback[rccs_pkg::STRENGTH_SEL_BIT] = st_r.strength_sel;
      readback[rccs_pkg::WAKE_STAT_BIT]    = st_r.wake != rccs_pkg::WK_IDLE;
      readback[rccs_pkg::KEEP0_HI_BIT]     = st_r.keep0_hi;
      readback[rccs_pkg::KEEP0_LO_BIT]     = st_r.keep0_lo;
      readback[rccs_pkg::PTI_SEL_BIT]      = st_r.pti_sel;
      readback[rccs_pkg::CLK_MHZ_LSB +: rccs_pkg::CLK_MHZ_W] = st_r.clk_mhz;
      readback[rccs_pkg::PWRDN_OK_BIT]     = st_r.pwrdn_ok;
      readback[rccs_pkg::SLOW_MON_BIT]     = st_r.slow_mon;
      readback[rccs_pkg::CLK_STAT_BIT]     = st_r.clk_stat; // RULE_11
      readback[rccs_pkg::SPARE_LSB +: 2]   = st_r.spare;
      readback[rccs_pkg::DIAG_OVR_BIT]     = st_r.diag_ovr;
      readback[rccs_pkg::ERR_MASK_BIT]     = st_r.err_mask;
      readback[rccs_pkg::ERR_ACK_BIT]      = 1'b0; // RULE_14
      readback[rccs_pkg::ERR_STAT_BIT]     = st_r.err_stat;
   end

   // byte lanes the master enables
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         byte_mask[i*8 +: 8] = {8{st_r.w_strb[i]}};
      end
   end

   assign merged  = (readback & ~byte_mask) | (st_r.w_data & byte_mask);
   assign wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
   assign wr_hit  = wr_fire & (st_r.aw_addr == rccs_pkg::CTRL2_ADDR);
   // action bits only act when their lane is written
   assign ack_wr  = wr_hit & st_r.w_strb[0]
                    & st_r.w_data[rccs_pkg::ERR_ACK_BIT];
   assign mon_clr = wr_hit & st_r.w_strb[0]
                    & ~st_r.w_data[rccs_pkg::SLOW_MON_BIT];

   always_comb begin
      st_nxt = st_r;

      // write address and data are taken in either order
      if (axi_req.awvalid && !st_r.aw_got) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !st_r.w_got) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = axi_req.wdata;
         st_nxt.w_strb = axi_req.wstrb;
      end

      // response once both halves are held
      if (wr_fire) begin
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = wr_hit ? rccs_pkg::RESP_OKAY
                                : rccs_pkg::RESP_DECERR;
      end
      if (st_r.bvalid && axi_req.bready) begin
         st_nxt.bvalid = 1'b0;
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
      end

      // software fields; status bits are not taken from the bus
      if (wr_hit) begin
         st_nxt.strength_sel = merged[rccs_pkg::STRENGTH_SEL_BIT];
         st_nxt.keep0_hi     = merged[rccs_pkg::KEEP0_HI_BIT];
         st_nxt.keep0_lo     = merged[rccs_pkg::KEEP0_LO_BIT];
         st_nxt.pti_sel      = merged[rccs_pkg::PTI_SEL_BIT];
         // no lock: software keeps this fixed after core enable
         st_nxt.clk_mhz      =
            merged[rccs_pkg::CLK_MHZ_LSB +: rccs_pkg::CLK_MHZ_W];
         st_nxt.spare        = merged[rccs_pkg::SPARE_LSB +: 2];
         st_nxt.diag_ovr     = merged[rccs_pkg::DIAG_OVR_BIT];
         st_nxt.err_mask     = merged[rccs_pkg::ERR_MASK_BIT];
      end

      // read: one word in flight, answered the next cycle
      if (axi_req.arvalid && !st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         if (axi_req.araddr == rccs_pkg::CTRL2_ADDR) begin
            st_nxt.rdata = readback;
            st_nxt.rresp = rccs_pkg::RESP_OKAY;
         end else begin
            st_nxt.rdata = '0;
            st_nxt.rresp = rccs_pkg::RESP_DECERR;
         end
      end else if (st_r.rvalid && axi_req.rready) begin
         st_nxt.rvalid = 1'b0;
      end

      // error status: acknowledge clears, a new fault wins
      if (ack_wr) begin
         st_nxt.err_stat = 1'b0; // RULE_14 RULE_16
      end
      if (exchange_mem_access_fault) begin
         st_nxt.err_stat = 1'b1; // RULE_15
      end

      // edge monitor: write-zero clears, a slow edge wins
      if (mon_clr) begin
         st_nxt.slow_mon = 1'b0; // RULE_09
      end
      if (slow_edge && !timer_in_reset) begin
         st_nxt.slow_mon = 1'b1; // RULE_09 RULE_10
      end

      // clock status follows the core
      st_nxt.clk_stat = core_on_master_clock; // RULE_11

      // power-down sequence counts slow edges after the request
      if (deep_sleep_request && !st_r.pwrdn_ok) begin
         st_nxt.pd_busy = 1'b1;
      end
      if (st_r.pd_busy && slow_edge) begin
         st_nxt.pd_cnt = st_r.pd_cnt + 4'h1;
         if (st_r.pd_cnt + 4'h1 == PD_LAST) begin
            st_nxt.pwrdn_ok = 1'b1; // RULE_07
            st_nxt.pd_busy  = 1'b0;
            st_nxt.pd_cnt   = '0;
         end
      end
      // sleep exit aborts or ends it; exit takes priority
      if (sleep_exit_interrupt) begin
         st_nxt.pwrdn_ok = 1'b0; // RULE_08
         st_nxt.pd_busy  = 1'b0;
         st_nxt.pd_cnt   = '0;
      end

      // wakeup pending: powered up, then one whole slow period
      unique case (st_r.wake)
         rccs_pkg::WK_IDLE: begin
            if (lowpower_wakeup_interrupt) begin
               st_nxt.wake = rccs_pkg::WK_PEND; // RULE_02
            end
         end
         rccs_pkg::WK_PEND: begin
            if (radio_powered_up && slow_edge) begin
               st_nxt.wake = rccs_pkg::WK_LAST;
            end else if (radio_powered_up) begin
               st_nxt.wake = rccs_pkg::WK_START;
            end
         end
         rccs_pkg::WK_START: begin
            // first edge opens the period
            if (slow_edge) begin
               st_nxt.wake = rccs_pkg::WK_LAST;
            end
         end
         rccs_pkg::WK_LAST: begin
            // next edge closes it; a fresh wakeup keeps it pending
            if (slow_edge) begin
               st_nxt.wake = lowpower_wakeup_interrupt ? rccs_pkg::WK_PEND
                                                       : rccs_pkg::WK_IDLE; // RULE_02
            end
         end
      endcase

      // diagnostic: overrule forces zero, else passes through
      st_nxt.diag = st_r.diag_ovr ? '0
                                  : core_diagnostic_output; // RULE_12
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r          <= '0;
         st_r.err_mask <= 1'b1; // RULE_13
         st_r.wake     <= rccs_pkg::WK_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // bus answers; ready only while the slot is free
   always_comb begin
      axi_rsp         = '0;
      axi_rsp.awready = ~st_r.aw_got;
      axi_rsp.wready  = ~st_r.w_got;
      axi_rsp.bvalid  = st_r.bvalid;
      axi_rsp.bresp   = st_r.bresp;
      axi_rsp.arready = ~st_r.rvalid;
      axi_rsp.rvalid  = st_r.rvalid;
      axi_rsp.rdata   = st_r.rdata;
      axi_rsp.rresp   = st_r.rresp;
   end

   // field outputs except wakeup status and error interrupt come straight from flip-flops
   assign signal_strength_source_select = st_r.strength_sel; // RULE_01
   assign pti_source_dynamic     = st_r.pti_sel; // RULE_04
   assign master_clock_mhz       = st_r.clk_mhz; // RULE_05
   assign powerdown_permitted    = st_r.pwrdn_ok;
   assign lowpower_wakeup_status = st_r.wake != rccs_pkg::WK_IDLE;
   assign diag_out               = st_r.diag;
   // level from flops, falls the cycle after acknowledge
   assign core_error_interrupt   = st_r.err_stat & st_r.err_mask; // RULE_13 RULE_18
endmodule : rccs_ctrl2

// File: rccs_assertions.sv
`timescale 1ns/10ps
// port-level checks of the radio core control register
module rccs_chk #(
   parameter int DIAG_W   = 8,
   parameter int PD_EDGES = 2
) (
   input wire logic                    aclk,
   input wire logic                    aresetn,
   input wire rccs_pkg::rccs_axi_req_t axi_req,
   input wire rccs_pkg::rccs_axi_rsp_t axi_rsp,
   input wire logic                    lowpower_wakeup_interrupt,
   input wire logic                    sleep_exit_interrupt,
   input wire logic                    exchange_mem_access_fault,
   input wire logic [DIAG_W-1:0]       core_diagnostic_output,
   input wire logic [DIAG_W-1:0]       diag_out,
   input wire logic                    powerdown_permitted,
   input wire logic                    lowpower_wakeup_status,
   input wire logic                    core_error_interrupt
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // read answers one cycle, write two cycles after the request is taken
   chk_rd_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read answer late");
   chk_wr_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready |-> ##2 axi_rsp.bvalid) else $error("write answer late");
   chk_unmapped_read: assert property (axi_req.arvalid && axi_rsp.arready
      && axi_req.araddr != rccs_pkg::CTRL2_ADDR
      |=> axi_rsp.rresp == rccs_pkg::RESP_DECERR && axi_rsp.rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_reserved_zero: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:22] == 10'h0
      && axi_rsp.rdata[16:15] == 2'h0 && axi_rsp.rdata[1] == 1'b0)
      else $error("reserved or ack bit read nonzero");
   // diag is either forced low or last cycle's core value
   chk_diag_pass: assert property (diag_out != '0
      |-> diag_out == $past(core_diagnostic_output))
      else $error("diag output not passed through");
   chk_wake_set: assert property (lowpower_wakeup_interrupt |=> lowpower_wakeup_status)
      else $error("wakeup status not set");
   chk_sleep_exit: assert property (sleep_exit_interrupt |=> !powerdown_permitted)
      else $error("powerdown flag kept after sleep exit");
   chk_err_cause: assert property ($rose(core_error_interrupt)
      |-> $past(exchange_mem_access_fault) || $rose(axi_rsp.bvalid))
      else $error("error interrupt without cause");
   // ack write lands with bvalid, interrupt low in that same cycle
   chk_err_ack_drop: assert property (axi_req.awvalid && axi_rsp.awready
      && axi_req.awaddr == rccs_pkg::CTRL2_ADDR && axi_req.wvalid && axi_rsp.wready
      && axi_req.wstrb[0] && axi_req.wdata[1] && !exchange_mem_access_fault
      ##1 !exchange_mem_access_fault |=> !core_error_interrupt)
      else $error("error interrupt kept after ack");
endmodule : rccs_chk

bind rccs_ctrl2 rccs_chk #(.DIAG_W(DIAG_W), .PD_EDGES(PD_EDGES)) u_rccs_chk (.aclk, .aresetn,
   .axi_req, .axi_rsp, .lowpower_wakeup_interrupt, .sleep_exit_interrupt,
   .exchange_mem_access_fault, .core_diagnostic_output, .diag_out, .powerdown_permitted,
   .lowpower_wakeup_status, .core_error_interrupt);

// File: rccs_ctrl2_tb.sv
`timescale 1ns/10ps
// self-checking bench, register model kept in plain variables
module rccs_ctrl2_tb;
   localparam logic [31:0] ADR = rccs_pkg::CTRL2_ADDR;
   localparam logic [31:0] RW  = 32'h002e_7e3c;
   logic                    aclk, aresetn, slow, trst, wake, pup, dsr, sx, mck, flt;
   logic                    sss, pti, pdp, wks, irq;
   logic [5:0]              mhz;
   logic [7:0]              dgi, dgo;
   rccs_pkg::rccs_axi_req_t req;
   rccs_pkg::rccs_axi_rsp_t rsp;
   logic [31:0]             mdl, seed, r, a;
   logic                    mon, err, mpd, wk;
   int                      mismatches, total_checks;

   rccs_ctrl2 #(.DIAG_W(8), .PD_EDGES(2)) u_rccs_ctrl2 (.aclk(aclk), .aresetn(aresetn),
      .axi_req(req), .axi_rsp(rsp), .slow_clk_pin(slow), .core_timer_reset(trst),
      .lowpower_wakeup_interrupt(wake), .radio_powered_up(pup), .deep_sleep_request(dsr),
      .sleep_exit_interrupt(sx), .core_on_master_clock(mck), .exchange_mem_access_fault(flt),
      .core_diagnostic_output(dgi), .diag_out(dgo), .signal_strength_source_select(sss),
      .pti_source_dynamic(pti), .master_clock_mhz(mhz), .powerdown_permitted(pdp),
      .lowpower_wakeup_status(wks), .core_error_interrupt(irq));

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // expected read value from the model state
   function automatic logic [31:0] expv();
      return (mdl & RW) | {11'h0, wk, 11'h0, mpd, mon, mck, 5'h0, err};
   endfunction : expv

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic fail(input logic [31:0] g, e);
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
   endtask : fail

   task automatic chk_word(input logic [31:0] g, e);
      total_checks++;
      if (g !== e) fail(g, e);
   endtask : chk_word

   task automatic chk_resp(input logic [1:0] g, e);
      total_checks++;
      if (g !== e) fail({30'h0, g}, {30'h0, e});
   endtask : chk_resp

   task automatic chk_pin(input logic [7:0] g, e);
      total_checks++;
      if (g !== e) fail({24'h0, g}, {24'h0, e});
   endtask : chk_pin

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc

   // one rising slow edge, long enough for the two-stage sync
   task automatic slow_edge();
      slow <= 1'b1;
      cyc(5);
      slow <= 1'b0;
      cyc(5);
   endtask : slow_edge

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [31:0] ad, d, input logic [3:0] s);
      logic pa;
      logic pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr  <= ad;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= s;
      req.bready  <= 1'b1;
      while (pa || pw) begin
         @(posedge aclk);
         if (pa && rsp.awready) begin
            pa = 1'b0;
            req.awvalid <= 1'b0;
         end
         if (pw && rsp.wready) begin
            pw = 1'b0;
            req.wvalid <= 1'b0;
         end
      end
      while (!rsp.bvalid) @(posedge aclk);
      req.bready <= 1'b0;
      chk_resp(rsp.bresp, ad == ADR ? rccs_pkg::RESP_OKAY : rccs_pkg::RESP_DECERR);
      if (ad == ADR) begin
         for (int i = 0; i < 4; i++) if (s[i]) mdl[i*8+:8] = d[i*8+:8];
         if (s[0] && !d[7]) mon = 1'b0;
         if (s[0] && d[1]) err = 1'b0;
      end
   endtask : wr

   task automatic rd(input logic [31:0] ad);
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr  <= ad;
      req.rready  <= 1'b1;
      do @(posedge aclk); while (!rsp.arready);
      req.arvalid <= 1'b0;
      do @(posedge aclk); while (!rsp.rvalid);
      req.rready <= 1'b0;
      chk_resp(rsp.rresp, ad == ADR ? rccs_pkg::RESP_OKAY : rccs_pkg::RESP_DECERR);
      chk_word(rsp.rdata, ad == ADR ? expv() : 32'h0);
   endtask : rd

   task automatic end_of_test();
      if (mismatches == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test

   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      cyc(20000);
      mismatches++;
      end_of_test();
   end

   initial begin
      {aresetn, slow, trst, wake, pup, dsr, sx, mck, flt, dgi} = '0;
      req = '0;
      seed = 32'hc486;
      {mon, err, mpd, wk} = 4'h0;
      mdl = rccs_pkg::CTRL2_RST;
      cyc(2);
      aresetn <= 1'b1;
      rd(ADR);
      // random fields, every fourth access unmapped; clock field set only here
      for (int i = 0; i < 12; i++) begin
         r = xs();
         a = (i % 4 == 3) ? ADR + 32'h4 : ADR;
         mck <= r[6];
         dgi <= r[31:24];
         wr(a, xs(), r[3:0]);
         rd(a);
         chk_pin({7'h0, sss}, {7'h0, mdl[21]});
         chk_pin({7'h0, pti}, {7'h0, mdl[17]});
         chk_pin({2'h0, mhz}, {2'h0, mdl[14:9]});
         chk_pin(dgo, mdl[3] ? 8'h0 : dgi);
      end
      // fault, masked, status write ignored, then acknowledged
      flt <= 1'b1;
      cyc(1);
      flt <= 1'b0;
      err = 1'b1;
      rd(ADR);
      chk_pin({7'h0, irq}, {7'h0, mdl[2]});
      for (int k = 0; k < 3; k++) begin
         wr(ADR, {24'h0, mdl[7:3], k != 0, k == 2, 1'b1}, 4'h1);
         rd(ADR);
         chk_pin({7'h0, irq}, {7'h0, err & mdl[2]});
      end
      // edge monitor blocked while the timer is held in reset
      for (int t = 1; t >= 0; t--) begin
         trst <= t[0];
         cyc(4);
         slow_edge();
         mon = !t[0];
         rd(ADR);
      end
      wr(ADR, {24'h0, mdl[7:0] & 8'h7d}, 4'h1);
      rd(ADR);
      dsr <= 1'b1;
      cyc(1);
      dsr <= 1'b0;
      cyc(4);
      chk_pin({7'h0, pdp}, 8'h0);
      repeat (2) slow_edge();
      {mon, mpd} = 2'b11;
      rd(ADR);
      sx <= 1'b1;
      cyc(1);
      sx <= 1'b0;
      mpd = 1'b0;
      rd(ADR);
      wake <= 1'b1;
      cyc(1);
      wake <= 1'b0;
      wk = 1'b1;
      rd(ADR);
      pup <= 1'b1;
      // handler polls bit 20 after each slow edge, leaves once clear
      for (int e = 0; e < 2; e++) begin
         cyc(2);
         slow_edge();
         wk = (e == 0);
         chk_pin({7'h0, wks}, {7'h0, wk});
         rd(ADR);
      end
      rd(ADR);
      end_of_test();
   end
endmodule : rccs_ctrl2_tb
